//--- shared/irq_reset_consts.svh
// Address, field and timing constants for the interrupt and reset logic.
`ifndef IRQ_RESET_CONSTS_SVH
`define IRQ_RESET_CONSTS_SVH
`define IRQ_REG_ADDR     16'hF7F0
`define IRQ_REG_MASK     16'hFFF8
`define NUM_IRQ_LINES    6
`define VEC_IRQ_ADDR     16'hFFF8
`define VEC_SWI_ADDR     16'hFFFA
`define VEC_NMI_ADDR     16'hFFFC
`define VEC_RESET_ADDR   16'hFFFE
`define RWM_TOP_ADDR     16'hF6FF
`define IO_BASE_ADDR     16'hF700
`define IO_TOP_ADDR      16'hF7FF
`define ROM_BASE_ADDR    16'hF800
`define DISP_LOW8_BASE   16'h6000
`define DISP_LOW4_BASE   16'h7000
`define DISP_HIGH4_BASE  16'hE000
`define DISP_LOW_TOP     16'h7FFF
`define DISP_HIGH_TOP    16'hEFFF
`define CRA_IRQ_OUT_LSB  3
`define CRA_IRQ_OUT_PAT  3'h6
`define CRB_FLAG_BIT     7
`define PRB_GRESET_BIT   6
`define PRA_KBRESET_BIT  1
`define POR_CYCLES       16
`define VSYNC_PERIOD_MS  20
`endif

//--- shared/irq_reset_pkg.sv
// Types shared by the interrupt and reset logic.
package irq_reset_pkg;
  typedef enum logic [1:0] {
    DISP_LOW8  = 2'h0,
    DISP_LOW4  = 2'h1,
    DISP_HIGH4 = 2'h2
  } disp_place_t;
  typedef enum logic [1:0] {
    POR_HOLD = 2'h0,
    POR_DONE = 2'h1
  } por_state_t;
endpackage : irq_reset_pkg

//--- src/reset_edge_flag.sv
// Sticky flag set on a rising edge of an input, cleared by a read pulse.
`timescale 1ns/1ns
module reset_edge_flag (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clock_enable,
  // Event and clear.
  input  wire logic level_in,
  input  wire logic clear,
  // Flag.
  output logic      flag_ff
);
  logic prev_ff;

  // Edge detection and sticky flag; a set beats a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else if (clock_enable) begin
      prev_ff <= level_in;
      if (level_in && !prev_ff) begin
        flag_ff <= 1'b1;
      end else if (clear) begin
        flag_ff <= 1'b0;
      end
    end
  end
endmodule : reset_edge_flag

//--- src/terminal_interrupt_reset_logic.sv
// Interrupt request, reset and address area logic of the terminal board.
`timescale 1ns/1ns
`include "irq_reset_consts.svh"
module terminal_interrupt_reset_logic
  import irq_reset_pkg::*;
#(
  parameter int POR_LEN = `POR_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  // Processor bus.
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_read,
  input  wire logic        cpu_valid,
  input  wire logic        vector_fetch,
  // Parallel adapter register state seen by this logic.
  input  wire logic [7:0]  adapter_ctrl_a,
  input  wire logic [7:0]  adapter_port_a,
  input  wire logic [7:0]  adapter_port_b,
  input  wire logic        crb_read,
  // Interrupt sources.
  input  wire logic        vsync_in,
  input  wire logic        keyboard_interrupt_line,
  input  wire logic        printer_interrupt_line,
  input  wire logic        link_interrupt_line,
  input  wire logic        modem_interrupt_line,
  // Test panel, reset button and display placement.
  input  wire logic        test_control_panel_inhibit,
  input  wire logic        test_control_panel_nmi,
  input  wire logic        reset_button,
  input  wire logic [1:0]  display_place,
  // Processor side outputs.
  output logic             cpu_irq_ff,
  output logic             cpu_nmi_ff,
  output logic             cpu_reset_ff,
  output logic [7:0]       read_data_ff,
  output logic             read_hit_ff,
  // Vector and area decode.
  output logic [1:0]       vector_sel_ff,
  output logic             vector_hit_ff,
  output logic             rwm_sel_ff,
  output logic             rom_sel_ff,
  output logic             io_sel_ff,
  output logic             display_sel_ff,
  // Board resets.
  output logic             adapter_reset_ff,
  output logic             general_reset_ff,
  output logic             reset_button_flag_ff,
  output logic             port_b_control_input_ff,
  output logic             keyboard_reset_output_ff
);
  localparam int NL = `NUM_IRQ_LINES;
  logic [NL-1:0]   lines;
  logic            soft_interrupt_line;
  logic            vsync_interrupt_line;
  logic            any_line;
  logic            reg_hit;
  logic            por_active;
  logic [15:0]     por_cnt_ff;
  por_state_t      por_state_ff;
  logic [15:0]     disp_base;
  logic [15:0]     disp_top;
  logic            nxt_irq;

  // Line zero fires when the control field holds the output pattern.
  assign soft_interrupt_line = (adapter_ctrl_a[`CRA_IRQ_OUT_LSB +: 3]
                                == `CRA_IRQ_OUT_PAT);
  // Vertical sync passes through the adapter as the periodic tick.
  assign vsync_interrupt_line = vsync_in;
  // Source line order in the interrupt register.
  assign lines = {modem_interrupt_line, link_interrupt_line,
                  printer_interrupt_line, keyboard_interrupt_line,
                  vsync_interrupt_line, soft_interrupt_line};
  assign any_line = |lines;
  assign nxt_irq = any_line && !test_control_panel_inhibit;
  assign reg_hit = cpu_valid
                   && ((cpu_addr & `IRQ_REG_MASK) == `IRQ_REG_ADDR);
  assign por_active = (por_state_ff == POR_HOLD);

  // Interrupt request and non-maskable request to the processor.
  always_ff @(posedge clock) begin
    if (reset) begin
      cpu_irq_ff <= 1'b0;
      cpu_nmi_ff <= 1'b0;
    end else if (clock_enable) begin
      cpu_irq_ff <= nxt_irq;
      cpu_nmi_ff <= test_control_panel_nmi;
    end
  end

  // Interrupt register: live line states, writes ignored, top bits zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data_ff <= 8'h00;
      read_hit_ff  <= 1'b0;
    end else if (clock_enable) begin
      read_hit_ff <= reg_hit && cpu_read;
      if (reg_hit && cpu_read) begin
        read_data_ff <= {2'h0, lines};
      end else begin
        read_data_ff <= 8'h00;
      end
    end
  end

  // Power-on counter holds processor, adapter and board in reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      por_cnt_ff   <= 16'h0000;
      por_state_ff <= POR_HOLD;
    end else if (clock_enable) begin
      if (por_state_ff == POR_HOLD) begin
        if (por_cnt_ff == 16'(POR_LEN - 1)) begin
          por_state_ff <= POR_DONE;
        end else begin
          por_cnt_ff <= por_cnt_ff + 16'h0001;
        end
      end
    end
  end

  // Reset outputs; the program reset touches only the board.
  always_ff @(posedge clock) begin
    if (reset) begin
      cpu_reset_ff     <= 1'b1;
      adapter_reset_ff <= 1'b1;
      general_reset_ff <= 1'b1;
    end else if (clock_enable) begin
      cpu_reset_ff     <= por_active || reset_button;
      adapter_reset_ff <= por_active;
      general_reset_ff <= por_active
                          || adapter_port_b[`PRB_GRESET_BIT];
    end
  end

  // Reset button feeds the port-B control input of the adapter.
  always_ff @(posedge clock) begin
    if (reset) begin
      port_b_control_input_ff <= 1'b0;
    end else if (clock_enable) begin
      port_b_control_input_ff <= reset_button;
    end
  end

  // Flag readable as control register B bit seven, cleared by that read.
  reset_edge_flag button_flag (
    .clock        (clock),
    .reset        (reset || por_active),
    .clock_enable (clock_enable),
    .level_in     (reset_button),
    .clear        (crb_read),
    .flag_ff      (reset_button_flag_ff)
  );

  // Keyboard reset follows port-A bit one.
  always_ff @(posedge clock) begin
    if (reset) begin
      keyboard_reset_output_ff <= 1'b0;
    end else if (clock_enable) begin
      keyboard_reset_output_ff <= adapter_port_a[`PRA_KBRESET_BIT];
    end
  end

  // Vector pair decode: 0 irq, 1 swi, 2 nmi, 3 reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      vector_sel_ff <= 2'h3;
      vector_hit_ff <= 1'b0;
    end else if (clock_enable) begin
      vector_hit_ff <= cpu_valid && vector_fetch
                       && (cpu_addr >= `VEC_IRQ_ADDR);
      vector_sel_ff <= cpu_addr[2:1];
    end
  end

  // Display area bounds from the placement choice.
  always_comb begin
    case (display_place)
      DISP_LOW8: begin
        disp_base = `DISP_LOW8_BASE;
        disp_top  = `DISP_LOW_TOP;
      end
      DISP_LOW4: begin
        disp_base = `DISP_LOW4_BASE;
        disp_top  = `DISP_LOW_TOP;
      end
      DISP_HIGH4: begin
        disp_base = `DISP_HIGH4_BASE;
        disp_top  = `DISP_HIGH_TOP;
      end
      default: begin
        disp_base = `DISP_LOW8_BASE;
        disp_top  = `DISP_LOW_TOP;
      end
    endcase
  end

  // Address area selects.
  always_ff @(posedge clock) begin
    if (reset) begin
      rwm_sel_ff     <= 1'b0;
      rom_sel_ff     <= 1'b0;
      io_sel_ff      <= 1'b0;
      display_sel_ff <= 1'b0;
    end else if (clock_enable) begin
      rwm_sel_ff <= cpu_valid && (cpu_addr <= `RWM_TOP_ADDR);
      io_sel_ff  <= cpu_valid && (cpu_addr >= `IO_BASE_ADDR)
                    && (cpu_addr <= `IO_TOP_ADDR);
      rom_sel_ff <= cpu_valid && cpu_read
                    && (cpu_addr >= `ROM_BASE_ADDR);
      display_sel_ff <= cpu_valid && (cpu_addr >= disp_base)
                        && (cpu_addr <= disp_top);
    end
  end

  // Request follows the OR of lines unless the panel inhibits it.
  chk_irq_follows: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable |=> cpu_irq_ff == $past(nxt_irq))
    else $error("irq request mismatch");
  chk_inhibit_wins: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && test_control_panel_inhibit |=> !cpu_irq_ff)
    else $error("inhibit ignored");
  // Register reads show the live lines; nothing shows outside a read.
  chk_reg_read: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && reg_hit && cpu_read
    |=> read_hit_ff && read_data_ff == {2'h0, $past(lines)})
    else $error("interrupt register data wrong");
  chk_reg_top_zero: assert property (
    @(posedge clock) disable iff (reset)
    read_data_ff[7:6] == 2'h0 && (read_hit_ff || read_data_ff == 8'h00))
    else $error("reserved bits nonzero");
  chk_write_ignored: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && reg_hit && !cpu_read
    |=> !read_hit_ff && read_data_ff == 8'h00)
    else $error("register write not ignored");
  // Line zero raises the request when the panel allows it.
  chk_soft_line: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && adapter_ctrl_a[5:3] == 3'h6 && !test_control_panel_inhibit
    |=> cpu_irq_ff)
    else $error("soft line missed");
  // Each reset source reaches only its own targets.
  chk_prog_reset: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !por_active && !reset_button
    && adapter_port_b[`PRB_GRESET_BIT]
    |=> general_reset_ff && !cpu_reset_ff && !adapter_reset_ff)
    else $error("program reset wrong");
  chk_button_reset: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && !por_active && reset_button
    |=> cpu_reset_ff && !adapter_reset_ff)
    else $error("button reset wrong");
  chk_por_all: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && por_active
    |=> cpu_reset_ff && adapter_reset_ff && general_reset_ff)
    else $error("power-on reset incomplete");
  // Button went down since the last enabled edge, outside the power-on hold.
  sequence button_edge_s;
    $past(clock_enable) && !$past(reset_button) && reset_button
    && clock_enable && !por_active;
  endsequence
  // Processor reset, adapter control input and sticky flag all follow.
  sequence button_seen_s;
    cpu_reset_ff && port_b_control_input_ff && reset_button_flag_ff;
  endsequence
  chk_button_flag: assert property (
    @(posedge clock) disable iff (reset)
    button_edge_s |=> button_seen_s)
    else $error("button flag not set");
  chk_flag_clear: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && crb_read && !reset_button |=> !reset_button_flag_ff)
    else $error("button flag not cleared");
  // Panel and adapter pass-through signals.
  chk_nmi_panel: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable |=> cpu_nmi_ff == $past(test_control_panel_nmi))
    else $error("nmi not from panel");
  chk_kb_reset: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable
    |=> keyboard_reset_output_ff == $past(adapter_port_a[1]))
    else $error("keyboard reset mismatch");
  // Vector fetches name their pair; the boot area answers only reads.
  chk_vector_pair: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && cpu_valid && vector_fetch && cpu_addr >= `VEC_IRQ_ADDR
    |=> vector_hit_ff && vector_sel_ff == $past(cpu_addr[2:1]))
    else $error("vector pair decode wrong");
  chk_rom_area: assert property (
    @(posedge clock) disable iff (reset)
    clock_enable && cpu_valid && cpu_read && cpu_addr >= `ROM_BASE_ADDR
    |=> rom_sel_ff && !rwm_sel_ff && !io_sel_ff)
    else $error("boot area wrong");
endmodule : terminal_interrupt_reset_logic

//--- tb/source_model.sv
// Model of the interrupt source chips that hold requests until serviced.
`timescale 1ns/1ns
module source_model (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       reset,
  // Raise and service strobes, one bit for each source.
  input  wire logic [4:0] raise,
  input  wire logic [4:0] service,
  // Held request levels.
  output logic      [4:0] lines_ff
);
  // A request stays up until serviced, since nothing downstream latches it.
  always_ff @(posedge clock) begin
    if (reset) begin
      lines_ff <= 5'h00;
    end else begin
      lines_ff <= (lines_ff | raise) & ~service;
    end
  end
endmodule : source_model

//--- tb/terminal_interrupt_reset_logic_bench.sv
// Self-checking bench for the interrupt, reset and decode logic.
`timescale 1ns/1ns
`include "irq_reset_consts.svh"
module terminal_interrupt_reset_logic_bench;
  import irq_reset_pkg::*;
  typedef struct {int due; int kind; int idx; logic [7:0] val;} note_t;
  logic clock = 1'b0, reset = 1'b1, clock_enable = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_read = 1'b0, cpu_valid = 1'b0, vector_fetch = 1'b0;
  logic [7:0] adapter_ctrl_a = 8'h00, adapter_port_a = 8'h00;
  logic [7:0] adapter_port_b = 8'h00;
  logic crb_read = 1'b0, test_control_panel_inhibit = 1'b0;
  logic test_control_panel_nmi = 1'b0, reset_button = 1'b0;
  logic [1:0] display_place = 2'h0;
  logic [4:0] raise = 5'h00, service = 5'h00;
  wire logic [4:0] src;
  wire logic cpu_irq_ff, cpu_nmi_ff, cpu_reset_ff, read_hit_ff;
  wire logic [7:0] read_data_ff;
  wire logic [1:0] vector_sel_ff;
  wire logic vector_hit_ff, rwm_sel_ff, rom_sel_ff, io_sel_ff;
  wire logic display_sel_ff, adapter_reset_ff, general_reset_ff;
  wire logic reset_button_flag_ff, port_b_control_input_ff;
  wire logic keyboard_reset_output_ff;
  wire logic [13:0] fl = {keyboard_reset_output_ff, port_b_control_input_ff,
    reset_button_flag_ff, general_reset_ff, adapter_reset_ff, display_sel_ff,
    io_sel_ff, rom_sel_ff, rwm_sel_ff, vector_hit_ff, read_hit_ff,
    cpu_reset_ff, cpu_nmi_ff, cpu_irq_ff};
  string fname [14] = '{"irq", "nmi", "cpu_reset", "read_hit", "vector_hit",
    "rwm_sel", "rom_sel", "io_sel", "display_sel", "adapter_reset",
    "general_reset", "button_flag", "port_b_ctl_in", "kb_reset"};
  note_t notes [$];
  note_t n;
  int cyc = 0, num_errors = 0, n_compared = 0, eff;
  logic [31:0] rnd = 32'h83CB03C0;
  logic [15:0] addrs [10] = '{16'h0000, 16'h5FFF, 16'h6000, 16'h7000,
    16'hE000, 16'hF6FF, 16'hF700, 16'hF7FF, 16'hF800, 16'hFFFF};

  // Design with a short power-on hold; partner drives lines one to five.
  terminal_interrupt_reset_logic #(.POR_LEN(2)) dut_u (.clock, .reset,
    .clock_enable, .cpu_addr, .cpu_read, .cpu_valid, .vector_fetch,
    .adapter_ctrl_a, .adapter_port_a, .adapter_port_b, .crb_read,
    .vsync_in(src[0]), .keyboard_interrupt_line(src[1]),
    .printer_interrupt_line(src[2]), .link_interrupt_line(src[3]),
    .modem_interrupt_line(src[4]), .test_control_panel_inhibit,
    .test_control_panel_nmi, .reset_button, .display_place, .cpu_irq_ff,
    .cpu_nmi_ff, .cpu_reset_ff, .read_data_ff, .read_hit_ff, .vector_sel_ff,
    .vector_hit_ff, .rwm_sel_ff, .rom_sel_ff, .io_sel_ff, .display_sel_ff,
    .adapter_reset_ff, .general_reset_ff, .reset_button_flag_ff,
    .port_b_control_input_ff, .keyboard_reset_output_ff);
  source_model src_u (.clock(clock), .reset(reset), .raise(raise),
    .service(service), .lines_ff(src));

  // Clock at 50 MHz.
  always #10 clock = ~clock;

  // Next value of the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  // Waits for the next rising edge.
  task automatic tick();
    @(posedge clock);
  endtask : tick

  // Notes a result due once the inputs set at this edge are sampled.
  task automatic note(input int kind, input int idx, input logic [7:0] v);
    notes.push_back('{cyc + 2, kind, idx, v});
  endtask : note

  // Compares one flag output.
  task automatic compare_flag(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %0b seen %0b", nm, e, s);
    end
  endtask : compare_flag

  // Compares one multi-bit output.
  task automatic compare_value(input string nm, input logic [7:0] e,
                               input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : compare_value

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Watches the outputs and checks them against the oldest notes.
  always @(negedge clock) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      if (n.kind == 0) begin
        compare_flag(fname[n.idx], n.val[0], fl[n.idx]);
      end else if (n.kind == 1) begin
        compare_value("read_data", n.val, read_data_ff);
      end else begin
        compare_value("vector_sel", n.val, {6'h00, vector_sel_ff});
      end
    end
  end

  // Cycle count and hang limit.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Main sequence.
  initial begin
    repeat (5) tick();
    reset <= 1'b0;
    note(0, 2, 1);
    note(0, 9, 1);
    note(0, 10, 1);
    repeat (6) tick();
    note(0, 2, 0);
    note(0, 10, 0);
    for (int i = 0; i < 6; i++) begin
      tick();
      rnd = lfsr(rnd);
      raise <= rnd[4:0];
      adapter_ctrl_a <= rnd[5] ? 8'h30 : 8'h00;
      tick();
      raise <= 5'h00;
      cpu_addr <= `IRQ_REG_ADDR | {13'h0000, rnd[8:6]};
      cpu_read <= 1'b1;
      cpu_valid <= 1'b1;
      test_control_panel_inhibit <= rnd[9];
      note(1, 0, {2'h0, rnd[4:0], rnd[5]});
      note(0, 3, 1);
      note(0, 0, !rnd[9] && (rnd[5:0] != 6'h00));
      tick();
      cpu_read <= 1'b0;
      note(0, 3, 0);
      note(1, 0, 8'h00);
      tick();
      cpu_valid <= 1'b0;
      service <= 5'h1F;
      adapter_ctrl_a <= 8'h00;
      tick();
      service <= 5'h00;
    end
    for (int i = 0; i < 4; i++) begin
      tick();
      vector_fetch <= 1'b1;
      cpu_read <= 1'b1;
      cpu_valid <= 1'b1;
      cpu_addr <= 16'(`VEC_IRQ_ADDR + 2 * i);
      note(2, 0, 8'(i));
      note(0, 4, 1);
      note(0, 6, 1);
    end
    tick();
    vector_fetch <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      for (int a = 0; a < 10; a++) begin
        tick();
        display_place <= 2'(p);
        cpu_addr <= addrs[a];
        eff = (p == 3) ? 0 : p;
        note(0, 5, addrs[a] <= 16'hF6FF);
        note(0, 7, addrs[a] >= 16'hF700 && addrs[a] <= 16'hF7FF);
        note(0, 6, addrs[a] >= 16'hF800);
        note(0, 4, 0);
        note(0, 8, (eff == 0 && addrs[a] inside {[16'h6000:16'h7FFF]})
          || (eff == 1 && addrs[a] inside {[16'h7000:16'h7FFF]})
          || (eff == 2 && addrs[a] inside {[16'hE000:16'hEFFF]}));
      end
    end
    tick();
    cpu_valid <= 1'b0;
    reset_button <= 1'b1;
    note(0, 2, 1);
    note(0, 9, 0);
    note(0, 10, 0);
    repeat (3) tick();
    note(0, 12, 1);
    note(0, 11, 1);
    tick();
    reset_button <= 1'b0;
    repeat (3) tick();
    note(0, 2, 0);
    note(0, 11, 1);
    tick();
    crb_read <= 1'b1;
    note(0, 11, 0);
    tick();
    crb_read <= 1'b0;
    adapter_port_b <= 8'h40;
    adapter_port_a <= 8'h02;
    test_control_panel_nmi <= 1'b1;
    note(0, 10, 1);
    note(0, 2, 0);
    note(0, 9, 0);
    note(0, 13, 1);
    note(0, 1, 1);
    tick();
    adapter_port_b <= 8'h00;
    adapter_port_a <= 8'h00;
    test_control_panel_nmi <= 1'b0;
    test_control_panel_inhibit <= 1'b0;
    note(0, 10, 0);
    note(0, 13, 0);
    note(0, 1, 0);
    tick();
    clock_enable <= 1'b0;
    raise <= 5'h04;
    tick();
    raise <= 5'h00;
    note(0, 0, 0);
    tick();
    clock_enable <= 1'b1;
    note(0, 0, 1);
    tick();
    reset <= 1'b1;
    note(2, 0, 8'h03);
    note(0, 2, 1);
    note(0, 0, 0);
    tick();
    reset <= 1'b0;
    note(0, 10, 1);
    repeat (4) tick();
    note(0, 2, 0);
    note(0, 10, 0);
    repeat (4) tick();
    print_verdict();
  end
endmodule : terminal_interrupt_reset_logic_bench
